/* rtl/tbc_pkg.sv */
package tbc_pkg;
	////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned STUCK_MS = 30;
	localparam int unsigned STUCK_CYC = CLK_HZ / 1000 * STUCK_MS;
	localparam int unsigned IDLE_US = 95;
	localparam int unsigned IDLE_CYC = CLK_HZ / 1_000_000 * IDLE_US;
	localparam int unsigned RECOV_GAP_US = 40;
	localparam int unsigned RECOV_GAP_CYC =
		(CLK_HZ / 1000 * RECOV_GAP_US + 999) / 1000;
	localparam int unsigned PULSE_HZ = 8500;
	localparam int unsigned PULSE_HALF_CYC = CLK_HZ / (2 * PULSE_HZ);
	localparam int unsigned PULSE_NUM = 16;
	localparam int unsigned TMR_W = 12;
	localparam int unsigned PCNT_W = 5;
	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic READY_RST = 1'b0;
	localparam logic PRECHARGE_RST = 1'b1;
	////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic data;
		logic clock;
	} tbc_pair_s;

	typedef enum logic [2:0] {
		ST_LOCKOUT,
		ST_WAIT_IDLE,
		ST_CONNECTED,
		ST_STUCK_GAP,
		ST_PULSE,
		ST_STOP
	} tbc_state_e;
endpackage : tbc_pkg

/* rtl/tbc_sync.sv */
module tbc_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;

	if (W < 1) begin : g_bad_w
		$error("tbc_sync: width must be at least one");
	end

	// idle bus lines are high, so the chain starts high
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				s1_q[i] <= 1'b1;
				s2_q[i] <= 1'b1;
			end else if (clk_en) begin
				s1_q[i] <= async_in[i];
				s2_q[i] <= s1_q[i];
			end
		end
	end
	assign sync_out = s2_q;
endmodule : tbc_sync

/* rtl/tbc_connect_ctrl.sv */
module tbc_connect_ctrl
	import tbc_pkg::*;
#(
	parameter int unsigned STUCK_CYCLES = STUCK_CYC,
	parameter int unsigned IDLE_CYCLES = IDLE_CYC
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// supply and host control
	input wire logic supply_good,
	input wire logic enable,
	// protected side pins
	input wire tbc_pair_s protected_side_in,
	output tbc_pair_s protected_side_out,
	output tbc_pair_s protected_side_oe,
	// recovery side pins
	input wire tbc_pair_s recovery_side_in,
	output tbc_pair_s recovery_side_out,
	output tbc_pair_s recovery_side_oe,
	// status
	output logic ready_out,
	output logic ready_oe,
	output logic precharge_en,
	output logic connected
);
	localparam int unsigned SW = $clog2(STUCK_CYCLES + 1);
	localparam int unsigned IW = $clog2(IDLE_CYCLES + 1);

	if (STUCK_CYCLES < 2 || IDLE_CYCLES < 2) begin : g_bad_param
		$error("tbc_connect_ctrl: timing counts too small");
	end

	////////////////////////////////////////////////////////////////////////
	// every pin passes two flops before use
	logic sup_s;
	logic en_s;
	tbc_pair_s [1:0] side_s;

	tbc_sync #(
		.W(6)
	) u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.async_in({supply_good, enable, protected_side_in,
			recovery_side_in}),
		.sync_out({sup_s, en_s, side_s[0], side_s[1]})
	);

	////////////////////////////////////////////////////////////////////////
	// control state
	tbc_state_e st_q, st_d;
	logic en_q, en_d;
	logic fault_q, fault_d;
	logic [TMR_W-1:0] tmr_q, tmr_d;
	logic [PCNT_W-1:0] pcnt_q, pcnt_d;
	logic ph_q, ph_d;
	tbc_pair_s [1:0] prev_q, prev_d;
	logic [1:0][IW-1:0] idle_q, idle_d;
	logic [1:0][SW-1:0] stk_q, stk_d;
	tbc_pair_s drv_p_q, drv_p_d;
	tbc_pair_s drv_r_q, drv_r_d;
	tbc_pair_s [1:0] echo_p_q, echo_p_d;
	tbc_pair_s [1:0] echo_r_q, echo_r_d;
	tbc_pair_s own_p;
	tbc_pair_s own_r;
	logic ready_q, ready_d;
	logic pre_q, pre_d;
	logic conn_q, conn_d;
	logic [1:0] side_idle;
	logic [1:0] side_stop;
	logic stuck;
	logic forced;
	logic stk_run;
	logic [1:0] rec_low;

	always_comb begin
		st_d = st_q;
		fault_d = fault_q;
		tmr_d = tmr_q;
		pcnt_d = pcnt_q;
		ph_d = ph_q;
		en_d = en_s;
		prev_d = side_s;
		rec_low = {~side_s[1].data, ~side_s[1].clock};
		forced = fault_q && en_s && !en_q && st_q != ST_LOCKOUT;
		// own recovery drive must not look like a stuck line
		stk_run = st_q == ST_WAIT_IDLE || st_q == ST_CONNECTED;
		for (int s = 0; s < 2; s++) begin
			if (side_s[s].data && side_s[s].clock) begin
				idle_d[s] = (idle_q[s] == IW'(IDLE_CYCLES)) ?
					idle_q[s] : idle_q[s] + IW'(1);
			end else begin
				idle_d[s] = '0;
			end
			side_idle[s] = idle_q[s] == IW'(IDLE_CYCLES);
			side_stop[s] = side_s[s].clock && side_s[s].data &&
				!prev_q[s].data;
			if (!rec_low[s] || forced) begin
				stk_d[s] = '0;
			end else if (stk_run && stk_q[s] != SW'(STUCK_CYCLES)) begin
				stk_d[s] = stk_q[s] + SW'(1);
			end else begin
				stk_d[s] = stk_q[s];
			end
		end
		stuck = stk_run && (stk_q[0] == SW'(STUCK_CYCLES) ||
			stk_q[1] == SW'(STUCK_CYCLES));
		unique case (st_q)
			ST_LOCKOUT: begin
				if (sup_s) begin
					st_d = ST_WAIT_IDLE;
				end
			end
			ST_WAIT_IDLE: begin
				if (stuck) begin
					st_d = ST_STUCK_GAP;
					fault_d = 1'b1;
					tmr_d = '0;
				end else if (en_s && ((side_idle[0] && side_idle[1]) ||
					(side_stop[0] && side_idle[1]) ||
					(side_stop[1] && side_idle[0]))) begin
					st_d = ST_CONNECTED;
					fault_d = 1'b0;
				end
			end
			ST_CONNECTED: begin
				if (!en_s) begin
					st_d = ST_WAIT_IDLE;
				end else if (stuck) begin
					st_d = ST_STUCK_GAP;
					fault_d = 1'b1;
					tmr_d = '0;
				end
			end
			ST_STUCK_GAP: begin
				tmr_d = tmr_q + TMR_W'(1);
				if (tmr_q == TMR_W'(RECOV_GAP_CYC - 1)) begin
					st_d = ST_PULSE;
					tmr_d = '0;
					pcnt_d = '0;
					ph_d = 1'b0;
				end
			end
			ST_PULSE: begin
				tmr_d = tmr_q + TMR_W'(1);
				if (tmr_q == TMR_W'(PULSE_HALF_CYC - 1)) begin
					tmr_d = '0;
					ph_d = !ph_q;
					if (ph_q) begin
						pcnt_d = pcnt_q + PCNT_W'(1);
						// stop early once the data line is freed
						if (pcnt_q == PCNT_W'(PULSE_NUM - 1) ||
							side_s[1].data) begin
							st_d = ST_STOP;
							ph_d = 1'b0;
						end
					end
				end
			end
			ST_STOP: begin
				tmr_d = tmr_q + TMR_W'(1);
				if (tmr_q == TMR_W'(PULSE_HALF_CYC - 1)) begin
					tmr_d = '0;
					ph_d = 1'b1;
					if (ph_q) begin
						st_d = ST_WAIT_IDLE;
					end
				end
			end
		endcase
		if (forced) begin
			st_d = ST_CONNECTED;
			// a new stuck event in the same cycle keeps the fault
			fault_d = stuck;
		end
		if (!sup_s) begin
			st_d = ST_LOCKOUT;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drives and status
	always_comb begin
		drv_p_d = '0;
		drv_r_d = '0;
		// a released line still reads low for two edges in the
		// synchroniser, so our own recent drive is masked that long
		echo_p_d = {echo_p_q[0], drv_p_q};
		echo_r_d = {echo_r_q[0], drv_r_q};
		own_p = drv_p_q | echo_p_q[0] | echo_p_q[1];
		own_r = drv_r_q | echo_r_q[0] | echo_r_q[1];
		unique case (st_d)
			ST_CONNECTED: begin
				// follow only lows made outside, else a driven low
				// would hold itself forever
				drv_r_d.data = !side_s[0].data && !own_p.data;
				drv_r_d.clock = !side_s[0].clock && !own_p.clock;
				drv_p_d.data = !side_s[1].data && !own_r.data &&
					!drv_r_d.data;
				drv_p_d.clock = !side_s[1].clock && !own_r.clock &&
					!drv_r_d.clock;
			end
			ST_PULSE: begin
				drv_r_d.clock = !ph_d;
			end
			ST_STOP: begin
				drv_r_d.data = 1'b1;
				drv_r_d.clock = !ph_d;
			end
			default: begin
				drv_p_d = '0;
			end
		endcase
		conn_d = st_d == ST_CONNECTED;
		ready_d = conn_d && en_s;
		pre_d = st_d == ST_LOCKOUT;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_LOCKOUT;
			en_q <= 1'b0;
			fault_q <= 1'b0;
			tmr_q <= '0;
			pcnt_q <= '0;
			ph_q <= 1'b0;
			prev_q <= '1;
			idle_q <= '0;
			stk_q <= '0;
			drv_p_q <= '0;
			drv_r_q <= '0;
			echo_p_q <= '0;
			echo_r_q <= '0;
			ready_q <= READY_RST;
			pre_q <= PRECHARGE_RST;
			conn_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			en_q <= en_d;
			fault_q <= fault_d;
			tmr_q <= tmr_d;
			pcnt_q <= pcnt_d;
			ph_q <= ph_d;
			prev_q <= prev_d;
			idle_q <= idle_d;
			stk_q <= stk_d;
			drv_p_q <= drv_p_d;
			drv_r_q <= drv_r_d;
			echo_p_q <= echo_p_d;
			echo_r_q <= echo_r_d;
			ready_q <= ready_d;
			pre_q <= pre_d;
			conn_q <= conn_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// open-drain pins only ever pull low; precharge_en and connected drive both levels
	assign protected_side_out = '0;
	assign recovery_side_out = '0;
	assign protected_side_oe = drv_p_q;
	assign recovery_side_oe = drv_r_q;
	assign ready_out = 1'b0;
	assign ready_oe = !ready_q;
	assign precharge_en = pre_q;
	assign connected = conn_q;
endmodule : tbc_connect_ctrl

/* test/tbc_bus_seg.sv */
module tbc_bus_seg
	import tbc_pkg::*;
(
	// drivers of one segment
	input wire tbc_pair_s drive_oe,
	input wire tbc_pair_s hold_low,
	// wired-and level
	output tbc_pair_s line
);
	timeunit 1ns;
	timeprecision 1ns;
	// pull-up: a released line reads high, not its last value
	assign line = ~(drive_oe | hold_low);
endmodule : tbc_bus_seg

/* test/tbc_connect_ctrl_monitor.sv */
module tbc_connect_ctrl_monitor
	import tbc_pkg::*;
#(
	parameter int unsigned STUCK_CYCLES = STUCK_CYC,
	parameter int unsigned IDLE_CYCLES = IDLE_CYC
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	// supply and host control
	input wire logic supply_good,
	input wire logic enable,
	// protected side pins
	input wire tbc_pair_s protected_side_in,
	input wire tbc_pair_s protected_side_out,
	input wire tbc_pair_s protected_side_oe,
	// recovery side pins
	input wire tbc_pair_s recovery_side_in,
	input wire tbc_pair_s recovery_side_out,
	input wire tbc_pair_s recovery_side_oe,
	// status
	input wire logic ready_out,
	input wire logic ready_oe,
	input wire logic precharge_en,
	input wire logic connected
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned low_n;
	int unsigned off_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// extra slack covers the two-flop synchroniser
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_n <= 0;
			off_n <= 0;
		end else begin
			low_n <= (recovery_side_in.clock || $rose(enable)) ? 0 : low_n + 1;
			off_n <= connected ? 0 : off_n + 1;
		end
	end
	a_enable_low: assert property (!enable[*4] |-> ready_oe && !connected)
		else $error("ready or join while disabled");
	a_ready_joined: assert property (!ready_oe |-> connected)
		else $error("ready released while apart");
	a_lockout_quiet: assert property (!supply_good[*4] |-> precharge_en &&
		!connected && recovery_side_oe == 2'b00 && protected_side_oe == 2'b00)
		else $error("activity during lockout");
	a_precharge_off: assert property (connected |-> !precharge_en)
		else $error("precharge on while joined");
	a_stuck_drop: assert property (low_n > STUCK_CYCLES + 8 |-> !connected)
		else $error("stuck bus still joined");
	a_gap_min: assert property ($rose(recovery_side_oe.clock) && !connected
		|-> off_n >= RECOV_GAP_CYC - 4)
		else $error("recovery clock too early");
	a_pulse_len: assert property ($rose(recovery_side_oe.clock) && !connected
		|-> recovery_side_oe.clock[*8])
		else $error("recovery pulse too short");
	a_stop_order: assert property ($fell(recovery_side_oe.data) && !connected
		|-> !recovery_side_oe.clock)
		else $error("stop without clock high");
	a_isolated: assert property (!connected |-> protected_side_oe == 2'b00)
		else $error("protected side driven while apart");
	c_join: cover property ($rose(connected));
	c_pulse: cover property ($rose(recovery_side_oe.clock) && !connected);
	c_stop: cover property ($fell(recovery_side_oe.data) && !connected);
endmodule : tbc_connect_ctrl_monitor

/* test/tbc_connect_ctrl_test.sv */
module tbc_connect_ctrl_test import tbc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STK = 200;
	localparam int IDL = 20;
	logic mclk, rst_n, clk_en, supply_good, enable;
	logic ready_out, ready_oe, precharge_en, connected;
	tbc_pair_s p_in, p_out, p_oe, r_in, r_out, r_oe, p_pull, r_pull;
	logic [3:0] ev;
	int n_fail = 0;
	int comparisons = 0;
	int n;
	initial mclk = 0;
	always #20 mclk = ~mclk;
	assign ev = {r_oe.data, r_oe.clock, !connected, connected};
	tbc_connect_ctrl #(.STUCK_CYCLES(STK), .IDLE_CYCLES(IDL)) tbc_connect_ctrl_i (
		.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
		.supply_good(supply_good), .enable(enable),
		.protected_side_in(p_in), .protected_side_out(p_out),
		.protected_side_oe(p_oe), .recovery_side_in(r_in),
		.recovery_side_out(r_out), .recovery_side_oe(r_oe),
		.ready_out(ready_out), .ready_oe(ready_oe),
		.precharge_en(precharge_en), .connected(connected));
	tbc_bus_seg prot_seg_i (.drive_oe(p_oe), .hold_low(p_pull), .line(p_in));
	tbc_bus_seg recov_seg_i (.drive_oe(r_oe), .hold_low(r_pull), .line(r_in));
	////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize
	task automatic check(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	// bounded wait; running out is a mismatch and ends the run
	task automatic wait_for(input int sel, input int lim);
		n = 0;
		while (ev[sel] !== 1'b1) begin
			@(negedge mclk);
			n++;
			if (n > lim) begin
				check(1'b0, 1'b1);
				summarize();
			end
		end
	endtask : wait_for
	task automatic t_lockout();
		p_pull = 2'b11;
		repeat (10) @(negedge mclk);
		check(precharge_en, 1'b1);
		check(connected, 1'b0);
		check(ready_oe, 1'b1);
		check(r_oe, 2'b00);
		check({ready_out, |(p_out | r_out)}, 2'b00);
		p_pull = 2'b00;
		$display("done lockout");
	endtask : t_lockout
	task automatic t_connect();
		supply_good = 1;
		wait_for(0, IDL + 20);
		check(n >= IDL, 1'b1);
		check(precharge_en, 1'b0);
		check(ready_oe, 1'b0);
		$display("done connect");
	endtask : t_connect
	task automatic t_pass();
		// protected clock frame at the 320 ns link period
		repeat (4) begin
			p_pull = 2'b01;
			#160;
			check(r_oe, 2'b01);
			p_pull = 2'b00;
			#160;
			check(r_oe, 2'b00);
		end
		// recovery data lows mirrored onto the protected side
		repeat (2) begin
			r_pull = 2'b10;
			#160;
			check(p_oe, 2'b10);
			r_pull = 2'b00;
			#160;
			check(p_oe, 2'b00);
		end
		// no drive may echo back once both sides are released
		repeat (8) begin
			@(negedge mclk);
			check(p_oe | r_oe, 2'b00);
		end
		$display("done pass through");
	endtask : t_pass
	task automatic t_enable();
		enable = 0;
		repeat (4) @(negedge mclk);
		check(connected, 1'b0);
		check(ready_oe, 1'b1);
		enable = 1;
		wait_for(0, IDL + 20);
		check(ready_oe, 1'b0);
		$display("done enable");
	endtask : t_enable
	task automatic t_stuck();
		r_pull = 2'b01;
		wait_for(1, STK + 20);
		check(n >= STK, 1'b1);
		check(ready_oe, 1'b1);
		enable = 0;
		repeat (5) @(negedge mclk);
		enable = 1;
		repeat (5) @(negedge mclk);
		check(connected, 1'b1);
		// a data blip must not restart the clock line's timer
		repeat (100) @(negedge mclk);
		r_pull = 2'b11;
		repeat (4) @(negedge mclk);
		r_pull = 2'b01;
		wait_for(1, STK + 20);
		check(n <= STK - 90, 1'b1);
		r_pull = 2'b00;
		wait_for(2, RECOV_GAP_CYC + 20);
		check(n >= RECOV_GAP_CYC - 4, 1'b1);
		wait_for(3, 4 * PULSE_HALF_CYC);
		check(r_oe, 2'b11);
		wait_for(0, 4 * PULSE_HALF_CYC + IDL + 20);
		$display("done stuck recovery");
	endtask : t_stuck
	task automatic t_relock();
		supply_good = 0;
		repeat (5) @(negedge mclk);
		check(precharge_en, 1'b1);
		check(connected, 1'b0);
		$display("done relock");
	endtask : t_relock
	initial begin
		rst_n = 0;
		clk_en = 1;
		supply_good = 0;
		enable = 1;
		p_pull = 2'b00;
		r_pull = 2'b00;
		repeat (20) @(negedge mclk);
		rst_n = 1;
		t_lockout();
		t_connect();
		t_pass();
		t_enable();
		t_stuck();
		t_relock();
		summarize();
	end
endmodule : tbc_connect_ctrl_test
bind tbc_connect_ctrl tbc_connect_ctrl_monitor #(.STUCK_CYCLES(STUCK_CYCLES),
	.IDLE_CYCLES(IDLE_CYCLES)) mon_i (.mclk(mclk), .rst_n(rst_n),
	.clk_en(clk_en), .supply_good(supply_good), .enable(enable),
	.protected_side_in(protected_side_in),
	.protected_side_out(protected_side_out),
	.protected_side_oe(protected_side_oe),
	.recovery_side_in(recovery_side_in),
	.recovery_side_out(recovery_side_out),
	.recovery_side_oe(recovery_side_oe), .ready_out(ready_out),
	.ready_oe(ready_oe), .precharge_en(precharge_en), .connected(connected));
